// [src/tap_port_pkg.sv]
// Purpose: Shared constants and types of the boundary-scan test port.
// Assumes: Three-bit instructions and a 32-bit identification register.
// Notes:   State codes step by one bit in the order the states are listed.

package tap_port_pkg;

  // ****************************************************************
  // Controller states.
  // ****************************************************************
  typedef enum logic [3:0] {
    TEST_RESET = 4'h0,
    RUN_IDLE   = 4'h1,
    SEL_DR     = 4'h3,
    CAP_DR     = 4'h2,
    SHIFT_DR   = 4'h6,
    EXIT1_DR   = 4'h7,
    PAUSE_DR   = 4'h5,
    EXIT2_DR   = 4'h4,
    UPD_DR     = 4'hc,
    SEL_IR     = 4'hd,
    CAP_IR     = 4'hf,
    SHIFT_IR   = 4'he,
    EXIT1_IR   = 4'ha,
    PAUSE_IR   = 4'hb,
    EXIT2_IR   = 4'h9,
    UPD_IR     = 4'h8
  } tap_state_t;

  // ****************************************************************
  // Instructions and data register choices.
  // ****************************************************************
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h2;
  localparam logic [IR_W-1:0] OP_USER = 3'h3;
  localparam logic [IR_W-1:0] OP_SAMPLEZ = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
  // Capture value of the instruction path; the two low bits are 01.
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_ID = 2'h1,
    SEL_BOUND = 2'h2,
    SEL_WORD = 2'h3
  } dr_sel_t;

  localparam int ID_W = 32;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int BS_LEN = 8;
  // Consecutive high mode-select edges that always reach reset.
  localparam int RESET_ONES = 5;

endpackage

// [src/tap_word_fifo.sv]
// Purpose: Word FIFO between user logic and the scan word register.
// Assumes: DEPTH is a power of two.
// Notes:   inReady comes straight from a flip-flop.

`timescale 1ns/1ns
`default_nettype none

module tap_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
  } fifo_st_t;

  fifo_st_t s_q;
  fifo_st_t s_d;
  logic push;
  logic pop;

  assign inReady = s_q.room;
  assign outValid = (s_q.cnt != '0);
  assign outData = s_q.mem[s_q.rp];
  assign push = inValid & s_q.room;
  assign pop = outReady & outValid;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = inData;
      s_d.wp = s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_d.room = (s_d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.room <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // tap_word_fifo

`default_nettype wire

// [src/boundary_scan_tap_port.sv]
// Purpose: Four-wire boundary-scan test port of a static memory device.
// Assumes: The test clock is far slower than ref_clk and is oversampled.
// Notes:   rst_n stands for power-up; there is no separate test reset pin.

`timescale 1ns/1ns
`default_nettype none

module boundary_scan_tap_port
  import tap_port_pkg::*;
#(
  // Arbitrary identification value; bit 0 is fixed at one.
  parameter logic [ID_W-1:0] ID_VALUE = 32'h00000001,
  parameter int BSLEN = BS_LEN,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tckDrive,
  input wire logic tms,
  input wire logic tmsDrive,
  input wire logic tdi,
  input wire logic tdiDrive,
  output logic tdoOut,
  output logic tdoOe,
  input wire logic [BSLEN-1:0] pinSample,
  output logic [BSLEN-1:0] bsDrive,
  output logic extestActive,
  output logic [IR_W-1:0] activeOp,
  input wire logic [WORD_W-1:0] wordData,
  input wire logic wordValid,
  output logic wordReady
);

  // ****************************************************************
  // State record.
  // ****************************************************************
  typedef struct packed {
    logic [2:0] tckS;
    logic [1:0] tmsS;
    logic [1:0] tdiS;
    logic [1:0][BSLEN-1:0] pinS;
    tap_state_t tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] irSh;
    logic [ID_W-1:0] dr;
    logic byp;
    logic [BSLEN-1:0] bsr;
    logic [BSLEN-1:0] bsUpd;
    logic extest;
    logic tdo;
    logic oe;
    logic pop;
  } tap_st_t;

  tap_st_t s_q;
  tap_st_t s_d;

  logic [WORD_W-1:0] fifoData;
  logic fifoValid;
  logic fifoReady;

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Unknown codes fall back to the bypass bit, as the standard asks.
  function automatic dr_sel_t drSelect(input logic [IR_W-1:0] op);
    dr_sel_t r;
    r = SEL_BYPASS;
    if (op == OP_IDCODE) begin
      r = SEL_ID;
    end else if (op == OP_EXTEST || op == OP_SAMPLE || op == OP_SAMPLEZ) begin
      r = SEL_BOUND;
    end else if (op == OP_USER) begin
      r = SEL_WORD;
    end
    return r;
  endfunction

  function automatic tap_state_t nextState(input tap_state_t st, input logic m);
    tap_state_t n;
    n = st;
    case (st)
      TEST_RESET: n = m ? TEST_RESET : RUN_IDLE;
      RUN_IDLE: n = m ? SEL_DR : RUN_IDLE;
      SEL_DR: n = m ? SEL_IR : CAP_DR;
      CAP_DR: n = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: n = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: n = m ? UPD_DR : PAUSE_DR;
      PAUSE_DR: n = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: n = m ? UPD_DR : SHIFT_DR;
      UPD_DR: n = m ? SEL_DR : RUN_IDLE;
      SEL_IR: n = m ? TEST_RESET : CAP_IR;
      CAP_IR: n = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: n = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: n = m ? UPD_IR : PAUSE_IR;
      PAUSE_IR: n = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: n = m ? UPD_IR : SHIFT_IR;
      UPD_IR: n = m ? SEL_DR : RUN_IDLE;
      default: n = TEST_RESET;
    endcase
    return n;
  endfunction

  // ****************************************************************
  // Pin conditioning.
  // ****************************************************************

  // Internal pull-ups: a pin nobody drives reads as one.
  logic tckPin;
  logic tmsPin;
  logic tdiPin;
  logic rise;
  logic fall;
  logic tmsNow;
  logic tdiNow;
  dr_sel_t sel;

  assign tckPin = tckDrive ? tck : 1'b1;
  assign tmsPin = tmsDrive ? tms : 1'b1;
  assign tdiPin = tdiDrive ? tdi : 1'b1;

  // Edges are found on the second and third stages only.
  assign rise = s_q.tckS[1] & ~s_q.tckS[2];
  assign fall = ~s_q.tckS[1] & s_q.tckS[2];
  assign tmsNow = s_q.tmsS[1];
  assign tdiNow = s_q.tdiS[1];
  assign sel = drSelect(s_q.ir);

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.tckS = {s_q.tckS[1:0], tckPin};
    s_d.tmsS = {s_q.tmsS[0], tmsPin};
    s_d.tdiS = {s_q.tdiS[0], tdiPin};
    s_d.pinS = {s_q.pinS[0], pinSample};
    s_d.pop = 1'b0;

    // All capture and shift action happens on the rising edge only.
    if (rise) begin
      case (s_q.tap)
        CAP_DR: begin
          if (sel == SEL_ID) begin
            s_d.dr = ID_VALUE;
          end else if (sel == SEL_WORD) begin
            // An empty queue captures zeros rather than stalling the scan.
            s_d.dr = fifoValid ? fifoData : '0;
            s_d.pop = fifoValid;
          end else if (sel == SEL_BOUND) begin
            s_d.bsr = s_q.pinS[1];
          end else begin
            s_d.byp = 1'b0;
          end
        end
        SHIFT_DR: begin
          if (sel == SEL_ID || sel == SEL_WORD) begin
            s_d.dr = {tdiNow, s_q.dr[ID_W-1:1]};
          end else if (sel == SEL_BOUND) begin
            s_d.bsr = {tdiNow, s_q.bsr[BSLEN-1:1]};
          end else begin
            s_d.byp = tdiNow;
          end
        end
        CAP_IR: begin
          s_d.irSh = IR_CAPTURE;
        end
        SHIFT_IR: begin
          s_d.irSh = {tdiNow, s_q.irSh[IR_W-1:1]};
        end
        default: begin
        end
      endcase
      // Five rising edges with mode-select high reach reset from anywhere.
      s_d.tap = nextState(s_q.tap, tmsNow);
    end

    // Output side moves on the falling edge, except that the reset state forces ir, extest and oe at once.
    if (fall) begin
      s_d.oe = (s_q.tap == SHIFT_DR) || (s_q.tap == SHIFT_IR);
      if (s_q.tap == SHIFT_IR) begin
        s_d.tdo = s_q.irSh[0];
      end else if (sel == SEL_ID || sel == SEL_WORD) begin
        s_d.tdo = s_q.dr[0];
      end else if (sel == SEL_BOUND) begin
        s_d.tdo = s_q.bsr[0];
      end else begin
        s_d.tdo = s_q.byp;
      end
      if (s_q.tap == UPD_IR) begin
        s_d.ir = s_q.irSh;
        s_d.extest = (s_q.irSh == OP_EXTEST);
      end
      if (s_q.tap == UPD_DR && sel == SEL_BOUND) begin
        s_d.bsUpd = s_q.bsr;
      end
    end

    // The reset state holds the identification read as the instruction.
    if (s_q.tap == TEST_RESET) begin
      s_d.ir = OP_IDCODE;
      s_d.extest = 1'b0;
      s_d.oe = 1'b0;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************

  // rst_n models power-up; no separate test reset pin exists.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.tckS <= 3'h7;
      s_q.tmsS <= 2'h3;
      s_q.tdiS <= 2'h3;
      s_q.tap <= TEST_RESET;
      s_q.ir <= OP_IDCODE;
      s_q.irSh <= OP_IDCODE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Word queue feeding the user data register.
  // ****************************************************************
  tap_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inData(wordData),
    .inValid(wordValid),
    .inReady(fifoReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(s_q.pop)
  );

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign tdoOut = s_q.tdo;
  assign tdoOe = s_q.oe;
  assign bsDrive = s_q.bsUpd;
  assign extestActive = s_q.extest;
  assign activeOp = s_q.ir;
  assign wordReady = fifoReady;

endmodule // boundary_scan_tap_port

`default_nettype wire

// [test/boundary_scan_tap_port_sva.sv]
// Purpose: Pin timing and reset checks on the boundary-scan test port.
// Assumes: The test clock is far slower than ref_clk.
// Notes:   Undriven clock and mode-select pins read as one.
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_tap_port_sva
  import tap_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tckDrive,
  input wire logic tms,
  input wire logic tmsDrive,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic extestActive,
  input wire logic [IR_W-1:0] activeOp,
  input wire logic wordValid,
  input wire logic wordReady
);
  logic tckEff, tmsEff, tckPrev_q;
  logic [2:0] onesCnt_q;
  logic [3:0] stillCnt_q;
  assign tckEff = tckDrive ? tck : 1'b1;
  assign tmsEff = tmsDrive ? tms : 1'b1;
  // The counters follow the raw pins, so they lead the synchronised view inside the port.
  always_ff @(posedge ref_clk) begin
    tckPrev_q <= tckEff;
    if (!rst_n) begin
      onesCnt_q <= 3'h0;
      stillCnt_q <= 4'h0;
    end else begin
      if (tckEff && !tckPrev_q) begin
        onesCnt_q <= (!tmsEff) ? 3'h0 : onesCnt_q + {2'h0, onesCnt_q != 3'h5};
      end
      stillCnt_q <= (tckEff != tckPrev_q) ? 4'h0 : stillCnt_q + {3'h0, stillCnt_q != 4'hf};
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_idle;
    activeOp == OP_IDCODE && !tdoOe && !extestActive;
  endsequence
  a_tdo_on_fall: assert property (($changed(tdoOut) || $changed(tdoOe)) |->
    !$past(tckEff) && $past(tckEff, 4)) else $error("serial output moved off a falling edge");
  a_quiet_no_clock: assert property (stillCnt_q >= 4'h5 |->
    $stable(activeOp) && $stable(tdoOe) && $stable(tdoOut)) else $error("port moved without clock");
  a_release_idle: assert property ($rose(rst_n) |-> s_idle)
    else $error("port not in reset state after power-up");
  a_five_ones_reset: assert property ($rose(onesCnt_q == 3'h5) |-> ##[1:6] s_idle)
    else $error("five high mode-select edges did not reset");
  a_oe_rise_shift: assert property ($rose(tdoOe) |-> onesCnt_q == 3'h0)
    else $error("output enabled outside a shift state");
  a_oe_fall_exit: assert property ($fell(tdoOe) |-> onesCnt_q != 3'h0)
    else $error("output disabled without mode-select high");
  a_extest_flag: assert property (extestActive == (activeOp == OP_EXTEST))
    else $error("external test flag disagrees with instruction");
  a_ready_fall_push: assert property ($fell(wordReady) |-> $past(wordValid))
    else $error("word queue filled without a push");
endmodule // boundary_scan_tap_port_sva
bind boundary_scan_tap_port boundary_scan_tap_port_sva chk (.ref_clk, .rst_n, .tck, .tckDrive,
  .tms, .tmsDrive, .tdoOut, .tdoOe, .extestActive, .activeOp, .wordValid, .wordReady);
`default_nettype wire

// [test/tap_host_model.sv]
// Purpose: Behavioural scan controller driving the test port pins.
// Assumes: One test clock period is 20 ref_clk cycles.
// Notes:   The test clock stands low between frames.
`timescale 1ns/1ns
`default_nettype none
module tap_host_model (
  input wire logic ref_clk,
  output logic tck,
  output logic tms,
  output logic tmsDrive,
  output logic tdi,
  output logic tdiDrive,
  input wire logic tdoOut,
  input wire logic tdoOe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tmsDrive = 1'b1;
    tdi = 1'b1;
    tdiDrive = 1'b1;
  end
  // Inputs move together with the fall, half a period from the rise.
  // A released pin toggles so that a stale level can never pass for the pull-up.
  task automatic step(input logic m, input logic d, input logic md, input logic dd,
      output logic o, output logic oe);
    tmsDrive <= md;
    tms <= md ? m : ~tms;
    tdiDrive <= dd;
    tdi <= dd ? d : ~tdi;
    repeat (10) @(posedge ref_clk);
    o = tdoOut;
    oe = tdoOe;
    tck <= 1'b1;
    repeat (10) @(posedge ref_clk);
    tck <= 1'b0;
  endtask
endmodule // tap_host_model
`default_nettype wire

// [test/tb_top.sv]
// Purpose: Self-checking bench for the boundary-scan test port.
// Assumes: The host model paces the test clock at 160 ns.
// Notes:   Expected values follow from the package constants.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import tap_port_pkg::*;
;
  // Arbitrary identification value; only bit 0 is fixed.
  localparam logic [ID_W-1:0] ID_ARB = 32'h5a3c9e01;
  logic ref_clk, rst_n, tck, tms, tmsDrive, tdi, tdiDrive, tdoOut, tdoOe;
  logic extestActive, wordValid, wordReady, tmsOn, tdiOn, seen, seenOe;
  logic [BS_LEN-1:0] pinSample, bsDrive;
  logic [IR_W-1:0] activeOp;
  logic [WORD_W-1:0] wordData, got;
  int badCount, samplesChecked;
  boundary_scan_tap_port #(.ID_VALUE(ID_ARB)) uut (.ref_clk, .rst_n, .tck, .tckDrive(1'b1),
    .tms, .tmsDrive, .tdi, .tdiDrive, .tdoOut, .tdoOe, .pinSample, .bsDrive, .extestActive,
    .activeOp, .wordData, .wordValid, .wordReady);
  tap_host_model host (.ref_clk, .tck, .tms, .tmsDrive, .tdi, .tdiDrive, .tdoOut, .tdoOe);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] val, input logic [31:0] exp);
    samplesChecked++;
    if (val !== exp) begin
      badCount++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, val, exp);
    end
  endtask
  task automatic st(input logic m, input logic d);
    host.step(m, d, tmsOn, tdiOn, seen, seenOe);
  endtask
  // Walks from idle or reset through one register scan and back to idle.
  task automatic scan(input bit isIr, input int n, input logic [31:0] din);
    got = '0;
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    if (isIr) st(1'b1, 1'b0);
    st(1'b0, 1'b0);
    st(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      st(i == n - 1, din[i]);
      got[i] = seen;
      check(seenOe, 1'b1);
    end
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
    check(seenOe, 1'b0);
  endtask
  task automatic testPower();
    #1;
    check(activeOp, OP_IDCODE);
    check({tdoOe, extestActive, bsDrive, wordReady}, 11'h1);
    repeat (60) @(posedge ref_clk);
    #1;
    check({activeOp, tdoOe}, {OP_IDCODE, 1'b0});
    @(posedge ref_clk);
    $display("done: power-up state");
  endtask
  task automatic testIdAndBypass();
    scan(1'b0, 32, 32'h0);
    check(got, ID_ARB);
    scan(1'b1, 3, OP_BYPASS);
    check(got[2:0], IR_CAPTURE);
    check(activeOp, OP_BYPASS);
    scan(1'b0, 8, 32'hb5);
    check(got[7:0], 8'h6a);
    $display("done: identification and bypass");
  endtask
  task automatic testCodes();
    logic [IR_W-1:0] ops [7] = '{OP_EXTEST, OP_IDCODE, OP_SAMPLE, OP_USER, OP_SAMPLEZ,
      OP_BYPASS, 3'h5};
    for (int k = 0; k < 7; k++) begin
      scan(1'b1, 3, ops[k]);
      check({activeOp, extestActive}, {ops[k], ops[k] === OP_EXTEST});
    end
    scan(1'b0, 4, 32'h9);
    check(got[3:0], 4'h2);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    scan(1'b1, 3, OP_BYPASS);
    check(got[2:0], IR_CAPTURE);
    $display("done: instruction codes and second reset");
  endtask
  task automatic testBoundary();
    pinSample <= 8'h96;
    scan(1'b1, 3, OP_SAMPLE);
    scan(1'b0, 8, 32'h3c);
    check(got[7:0], 8'h96);
    pinSample <= 8'h41;
    scan(1'b1, 3, OP_EXTEST);
    check({extestActive, bsDrive}, 9'h13c);
    scan(1'b0, 8, 32'h0);
    check({got[7:0], bsDrive}, 16'h4100);
    $display("done: boundary register");
  endtask
  task automatic testUndriven();
    scan(1'b1, 3, OP_SAMPLE);
    tmsOn = 1'b0;
    repeat (5) st(1'b0, 1'b0);
    tmsOn = 1'b1;
    check(activeOp, OP_IDCODE);
    scan(1'b1, 3, OP_SAMPLE);
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
    st(1'b0, 1'b0);
    repeat (5) st(1'b1, 1'b0);
    check({activeOp, seenOe}, {OP_IDCODE, 1'b0});
    tdiOn = 1'b0;
    scan(1'b1, 3, 32'h0);
    tdiOn = 1'b1;
    check(activeOp, OP_BYPASS);
    $display("done: undriven inputs and forced reset");
  endtask
  task automatic testWords();
    scan(1'b1, 3, OP_USER);
    wordValid <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      wordData <= 32'hc0de0000 + i;
      @(posedge ref_clk);
    end
    wordData <= 32'hbad0bad0;
    repeat (3) @(posedge ref_clk);
    #1;
    check(wordReady, 1'b0);
    @(posedge ref_clk);
    wordValid <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      scan(1'b0, 32, 32'h0);
      check(got, 32'hc0de0000 + i);
      check(wordReady, 1'b1);
    end
    scan(1'b0, 32, 32'h0);
    check(got, 32'h0);
    $display("done: word queue fill and drain");
  endtask
  task automatic reportAndStop();
    $display("checks %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    wordValid = 1'b0;
    wordData = '0;
    pinSample = '0;
    tmsOn = 1'b1;
    tdiOn = 1'b1;
    badCount = 0;
    samplesChecked = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    testPower();
    testIdAndBypass();
    testCodes();
    testBoundary();
    testUndriven();
    testWords();
    reportAndStop();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    badCount++;
    reportAndStop();
  end
endmodule // tb_top
`default_nettype wire
